// ==== core/trig_cfg.svh ====
// constants for the camera trigger pulse generator: offsets, fields, resets, timing
`ifndef TRIG_CFG_SVH
`define TRIG_CFG_SVH

// ==========================================================
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DELAY 8'h04
`define OFS_WIDTH 8'h08
`define OFS_BLANK 8'h0c
`define OFS_LINES 8'h10
`define OFS_POWER 8'h14
`define OFS_STATUS 8'h18

// ==========================================================
// field widths and positions
`define DELAY_W 12
`define WIDTH_W 16
`define BLANK_W 16
`define CNT_W 17
`define CTRL_W 21
`define LINES_POL_LSB 0
`define LINES_LVL_LSB 4
`define POWER_SEL_LSB 0
`define POWER_EN_BIT 3

// ==========================================================
// start mode codes held in the ctrl register
`define MODE_CONT 3'h0
`define MODE_LINE 3'h1
`define MODE_A 3'h2
`define MODE_B 3'h3
`define MODE_AB_UP 3'h4
`define MODE_AB_DN 3'h5

// ==========================================================
// reset values
`define CTRL_RST 21'h000000
`define DELAY_RST 12'h000
`define WIDTH_RST 16'h0000
`define BLANK_RST 16'h0000
`define LINES_RST 8'h00
`define POWER_RST 4'h0

// ==========================================================
// timing
`define CLK_MHZ 200
`define BASE_MHZ 50
`define BASE_DIV (`CLK_MHZ / `BASE_MHZ)
`define BLANK_EXTRA 3
`define POWER_STEP_MS 500
`define POWER_STEP_CYCLES (`POWER_STEP_MS * 1000 * `CLK_MHZ)

`endif

// ==== core/trig_pkg.sv ====
// types shared by the camera trigger pulse generator
package trig_pkg;

    // ======================================================
    // main control word, msb first
    typedef struct packed {
        logic trig_output_two_invert;
        logic trig_output_one_invert;
        logic page_invert;
        logic line_invert;
        logic encoder_z_invert;
        logic encoder_b_invert;
        logic encoder_a_invert;
        logic ext_trig_enable;
        logic ext_trig_invert;
        logic ext_out_trig;
        logic use_ext_ref;
        logic [1:0] control_line_select;
        logic control_line_four_option;
        logic control_line_three_option;
        logic control_line_two_option;
        logic control_line_one_option;
        logic [2:0] start_mode;
        logic run;
    } ctrl_t;

    // one bit per synchronised input, in the order they are packed
    typedef struct packed {
        logic ext_ref;
        logic page;
        logic enc_z;
        logic enc_b;
        logic enc_a;
        logic line;
        logic ext_trig;
    } pins_t;

    // phases of one trigger cycle
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_WIDTH,
        ST_BLANK
    } phase_t;

endpackage : trig_pkg

// ==== core/camera_trigger_pulse_generator.sv ====
// camera trigger pulse generator: register port, input conditioning, cycle shaper, cable power
//
// Behaviour
// - cc1 or cc2 option puts the delay/width/blank cycle on line one.
// - line three never carries a trigger waveform.
// - line four option runs on internal base, or external reference when selected.
// - a switch selects the external reference clock as time base.
// - default counts step in 20 ns ticks of a 50 MHz base.
// - external output trigger option uses external reference ticks for counting.
// - external output trigger option drives line four with the trigger.
// - delay takes 0..4095, width and blank take 0..65535.
// - all-zero settings give a 100 ns period, one tick high.
// - larger width lengthens pulse, larger blank lengthens gap.
// - continuous mode repeats cycles freely with no start event.
// - line trigger mode starts one cycle per rising line edge.
// - phase A or B mode starts a cycle on that phase rising.
// - combined phase rise mode starts on rising combined phase.
// - combined phase fall mode starts on falling combined phase.
// - start mode applies to lines one, two and four, never three.
// - external trigger invert flips the external trigger input.
// - external trigger enable gates external trigger events.
// - encoder A, B, Z each have their own input invert.
// - line and page trigger inputs each have their own invert.
// - trigger outputs on lines one and two each have an invert.
// - cable power delay selectable 0.5 s to 4 s in half steps.
// - four-bit mask makes each control line active high.
`timescale 1ns/1ps
`include "trig_cfg.svh"

module camera_trigger_pulse_generator
    import trig_pkg::*;
#(
    parameter int unsigned POWER_STEP = `POWER_STEP_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [31:0] rdata_o,
    input wire logic ext_trig_i,
    input wire logic line_trig_i,
    input wire logic page_trig_i,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_z_i,
    input wire logic ext_reference_input_i,
    output logic [3:0] cc_o,
    output logic page_pulse_o,
    output logic index_pulse_o,
    output logic cable_power_o
);

    // ======================================================
    // helpers

    // rising edge of a conditioned level against its previous sample
    function automatic logic rise(input logic now_v, input logic old_v);
        rise = now_v & ~old_v;
    endfunction : rise

    // final line level: active-high mask bit keeps it, clear bit inverts
    function automatic logic drive(input logic level, input logic high_act);
        drive = high_act ? level : ~level;
    endfunction : drive

    // ======================================================
    // registers
    ctrl_t ctrl_q;
    logic [`DELAY_W-1:0] delay_q;
    logic [`WIDTH_W-1:0] width_q;
    logic [`BLANK_W-1:0] blank_q;
    logic [7:0] lines_q;
    logic [3:0] power_q;
    logic [31:0] rdata_q;

    // address decode
    wire sel_ctrl = (addr_i == `OFS_CTRL);
    wire sel_delay = (addr_i == `OFS_DELAY);
    wire sel_width = (addr_i == `OFS_WIDTH);
    wire sel_blank = (addr_i == `OFS_BLANK);
    wire sel_lines = (addr_i == `OFS_LINES);
    wire sel_power = (addr_i == `OFS_POWER);
    wire sel_status = (addr_i == `OFS_STATUS);

    // register writes; fields are sized so out-of-range values cannot be stored
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= `CTRL_RST;
            delay_q <= `DELAY_RST;
            width_q <= `WIDTH_RST;
            blank_q <= `BLANK_RST;
            lines_q <= `LINES_RST;
            power_q <= `POWER_RST;
        end else if (write_i) begin
            if (sel_ctrl) ctrl_q <= ctrl_t'(wdata_i[`CTRL_W-1:0]);
            if (sel_delay) delay_q <= wdata_i[`DELAY_W-1:0];
            if (sel_width) width_q <= wdata_i[`WIDTH_W-1:0];
            if (sel_blank) blank_q <= wdata_i[`BLANK_W-1:0];
            if (sel_lines) lines_q <= wdata_i[7:0];
            if (sel_power) power_q <= wdata_i[3:0];
        end
    end

    // ======================================================
    // input synchronisers: two stages, then conditioning
    pins_t meta_q;
    pins_t sync_q;
    pins_t cond_d;
    pins_t cond_q;
    wire pins_t raw = '{ext_ref: ext_reference_input_i, page: page_trig_i, enc_z: enc_z_i,
                        enc_b: enc_b_i, enc_a: enc_a_i, line: line_trig_i,
                        ext_trig: ext_trig_i};

    // only sync_q reads meta_q
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    // per-input polarity after synchronisation, before any edge detector
    always_comb begin
        cond_d = sync_q;
        cond_d.ext_trig = sync_q.ext_trig ^ ctrl_q.ext_trig_invert;
        cond_d.enc_a = sync_q.enc_a ^ ctrl_q.encoder_a_invert;
        cond_d.enc_b = sync_q.enc_b ^ ctrl_q.encoder_b_invert;
        cond_d.enc_z = sync_q.enc_z ^ ctrl_q.encoder_z_invert;
        cond_d.line = sync_q.line ^ ctrl_q.line_invert;
        cond_d.page = sync_q.page ^ ctrl_q.page_invert;
    end

    // previous conditioned sample; an invert toggle may look like one edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cond_q <= '0;
        end else begin
            cond_q <= cond_d;
        end
    end

    // combined phase is the xor of A and B, doubling the encoder rate
    wire ab_now = cond_d.enc_a ^ cond_d.enc_b;
    wire ab_old = cond_q.enc_a ^ cond_q.enc_b;

    // edge pulses, one clock each
    wire line_edge = rise(cond_d.line, cond_q.line);
    wire a_edge = rise(cond_d.enc_a, cond_q.enc_a);
    wire b_edge = rise(cond_d.enc_b, cond_q.enc_b);
    wire ab_up_edge = rise(ab_now, ab_old);
    wire ab_dn_edge = rise(ab_old, ab_now);
    wire ext_edge = rise(cond_d.ext_trig, cond_q.ext_trig) & ctrl_q.ext_trig_enable;
    wire ref_edge = rise(cond_d.ext_ref, cond_q.ext_ref);

    // ======================================================
    // base tick: internal 50 MHz divider or the external reference
    localparam logic [1:0] DIV_LAST = 2'(`BASE_DIV - 1);
    logic [1:0] div_q;
    // ext output option counts reference ticks too
    wire ext_base = ctrl_q.use_ext_ref | ctrl_q.ext_out_trig;
    wire int_tick = (div_q == DIV_LAST);
    wire tick = ext_base ? ref_edge : int_tick;

    // free-running divider keeps a steady 20 ns base
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_q <= '0;
        end else begin
            div_q <= int_tick ? 2'h0 : div_q + 2'h1;
        end
    end

    // ======================================================
    // start selection
    logic mode_edge;
    // codes 6 and 7 give no mode edge; only an enabled external trigger starts a cycle there
    always_comb begin
        case (ctrl_q.start_mode)
            `MODE_LINE: mode_edge = line_edge;
            `MODE_A: mode_edge = a_edge;
            `MODE_B: mode_edge = b_edge;
            `MODE_AB_UP: mode_edge = ab_up_edge;
            `MODE_AB_DN: mode_edge = ab_dn_edge;
            default: mode_edge = 1'b0;
        endcase
    end

    wire continuous = (ctrl_q.start_mode == `MODE_CONT);

    // edges while a cycle runs are dropped, so each taken edge makes exactly one cycle
    wire start = ctrl_q.run & (continuous | mode_edge | ext_edge);

    // ======================================================
    // cycle shaper
    phase_t phase_q;
    phase_t phase_d;
    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_d;
    logic [15:0] cycles_q;

    wire [`CNT_W-1:0] delay_load = `CNT_W'(delay_q) - `CNT_W'(1);
    wire [`CNT_W-1:0] width_load = `CNT_W'(width_q);
    wire [`CNT_W-1:0] blank_load = `CNT_W'(blank_q) + `CNT_W'(`BLANK_EXTRA);
    wire phase_done = tick & (cnt_q == '0);
    wire begin_cycle = (phase_q == ST_IDLE) & start;

    // delay (may be empty), pulse of width+1 ticks, gap of blank+4 ticks
    always_comb begin
        phase_d = phase_q;
        cnt_d = tick ? cnt_q - `CNT_W'(1) : cnt_q;
        case (phase_q)
            ST_IDLE: begin
                cnt_d = cnt_q;
                if (start) begin
                    phase_d = (delay_q == '0) ? ST_WIDTH : ST_DELAY;
                    cnt_d = (delay_q == '0) ? width_load : delay_load;
                end
            end
            ST_DELAY: begin
                if (phase_done) begin
                    phase_d = ST_WIDTH;
                    cnt_d = width_load;
                end
            end
            ST_WIDTH: begin
                if (phase_done) begin
                    phase_d = ST_BLANK;
                    cnt_d = blank_load;
                end
            end
            ST_BLANK: begin
                if (phase_done) begin
                    phase_d = ST_IDLE;
                    cnt_d = '0;
                    // continuous mode goes straight into the next cycle
                    if (ctrl_q.run & continuous) begin
                        phase_d = (delay_q == '0) ? ST_WIDTH : ST_DELAY;
                        cnt_d = (delay_q == '0) ? width_load : delay_load;
                    end
                end
            end
            default: begin
                phase_d = ST_IDLE;
                cnt_d = '0;
            end
        endcase
        // clearing run aborts a cycle at once
        if (!ctrl_q.run) begin
            phase_d = ST_IDLE;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
        end
    end

    // count of cycles begun, wraps; software can see activity without sampling lines
    wire cont_restart = (phase_q == ST_BLANK) & phase_done & ctrl_q.run & continuous;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cycles_q <= '0;
        end else if (begin_cycle | cont_restart) begin
            cycles_q <= cycles_q + 16'h0001;
        end
    end

    // ======================================================
    // control line outputs
    wire pulse = (phase_q == ST_WIDTH);
    wire [3:0] cc_pol = lines_q[`LINES_POL_LSB +: 4];
    wire [3:0] cc_lvl = lines_q[`LINES_LVL_LSB +: 4];

    // lines that carry the trigger
    wire line1_trig = ctrl_q.control_line_one_option | ctrl_q.control_line_two_option;
    wire line2_trig = (ctrl_q.control_line_select == 2'h1);
    wire line4_trig = ctrl_q.ext_out_trig | ctrl_q.control_line_four_option;
    logic [3:0] cc_d;
    logic [3:0] cc_q;

    // lines without a trigger show their static level
    always_comb begin
        cc_d[0] = drive(line1_trig ? pulse ^ ctrl_q.trig_output_one_invert : cc_lvl[0],
                        cc_pol[0]);
        cc_d[1] = drive(line2_trig ? pulse ^ ctrl_q.trig_output_two_invert : cc_lvl[1],
                        cc_pol[1]);
        cc_d[2] = drive(cc_lvl[2], cc_pol[2]);
        cc_d[3] = drive(line4_trig ? pulse : cc_lvl[3], cc_pol[3]);
    end

    // registered so the lines are glitch free
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cc_q <= 4'h0;
        end else begin
            cc_q <= cc_d;
        end
    end

    // page and index pulses go to the frame sequencer outside this block
    logic page_q;
    logic index_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            page_q <= 1'b0;
            index_q <= 1'b0;
        end else begin
            page_q <= rise(cond_d.page, cond_q.page);
            index_q <= rise(cond_d.enc_z, cond_q.enc_z);
        end
    end

    // ======================================================
    // cable power delay: (sel+1) half-second steps after enable
    logic [31:0] pwr_cnt_q;
    logic pwr_on_q;
    wire pwr_en = power_q[`POWER_EN_BIT];
    wire [2:0] pwr_sel = power_q[`POWER_SEL_LSB +: 3];
    wire [31:0] pwr_target = 32'(POWER_STEP) * (32'(pwr_sel) + 32'h1);

    // disabling drops power at once and restarts the wait
    always_ff @(posedge clk_i) begin
        if (reset_i | ~pwr_en) begin
            pwr_cnt_q <= '0;
            pwr_on_q <= 1'b0;
        end else if (!pwr_on_q) begin
            pwr_cnt_q <= pwr_cnt_q + 32'h1;
            pwr_on_q <= (pwr_cnt_q + 32'h1 >= pwr_target);
        end
    end

    // ======================================================
    // read port, data one cycle after the strobe, unmapped reads zero
    wire [31:0] status_word = {cycles_q, 12'h000, pwr_on_q, phase_q, phase_q != ST_IDLE};
    wire [31:0] read_mux = sel_ctrl ? 32'(ctrl_q) :
                           sel_delay ? 32'(delay_q) :
                           sel_width ? 32'(width_q) :
                           sel_blank ? 32'(blank_q) :
                           sel_lines ? 32'(lines_q) :
                           sel_power ? 32'(power_q) :
                           sel_status ? status_word : 32'h0;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= read_i ? read_mux : 32'h0;
        end
    end

    // outputs come from flip-flops
    assign rdata_o = rdata_q;
    assign cc_o = cc_q;
    assign page_pulse_o = page_q;
    assign index_pulse_o = index_q;
    assign cable_power_o = pwr_on_q;

endmodule : camera_trigger_pulse_generator

// ==== test/trig_pulse_chk.sv ====
// port checker for the camera trigger pulse generator
`timescale 1ns/1ps
`include "trig_cfg.svh"

module trig_pulse_chk #(
    parameter int unsigned POWER_STEP = 10
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [31:0] rdata_o,
    input wire logic [3:0] cc_o,
    input wire logic index_pulse_o,
    input wire logic cable_power_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ==========================================================
    // shadow of software settings
    logic [31:0] sh_q [0:5];
    logic [2:0] calm_q;
    logic [11:0] pwr_q;
    wire logic hit = write_i && addr_i <= `OFS_POWER && addr_i[1:0] == 2'h0;
    wire logic calm = calm_q == 3'h7;
    wire logic [31:0] ctl = sh_q[0];
    wire logic [3:0] lns = sh_q[4][3:0];
    wire logic [3:0] lvl = sh_q[4][7:4];
    wire logic [11:0] pwr_exp = 12'(({9'h0, sh_q[5][2:0]} + 12'h1) * POWER_STEP);
    wire logic zcfg = calm && ctl[0] && ctl[3:1] == 3'h0 && (ctl[4] || ctl[5]) && !ctl[10]
        && !ctl[11] && !ctl[13] && sh_q[1][11:0] == 12'h0 && sh_q[2][15:0] == 16'h0
        && sh_q[3][15:0] == 16'h0;

    // line levels and the power-off check are only judged once writes have had seven cycles to land
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sh_q <= '{default: 32'h0};
            calm_q <= 3'h0;
            pwr_q <= 12'h0;
        end else begin
            if (hit)
                sh_q[addr_i[4:2]] <= wdata_i;
            calm_q <= write_i ? 3'h0 : (calm ? calm_q : calm_q + 3'h1);
            pwr_q <= !sh_q[5][3] ? 12'h0 : (cable_power_o ? pwr_q : pwr_q + 12'h1);
        end
    end

    // ==========================================================
    // assertions
    a_delay_read: assert property (
        read_i && addr_i == `OFS_DELAY |=> rdata_o == {20'h0, sh_q[1][11:0]})
        else $error("delay readback wrong");
    a_width_read: assert property (
        read_i && addr_i == `OFS_WIDTH |=> rdata_o == {16'h0, sh_q[2][15:0]})
        else $error("width readback wrong");
    a_line3_static: assert property (
        calm |-> cc_o[2] == (lvl[2] ~^ lns[2])) else $error("line three not static");
    a_line1_static: assert property (
        calm && !ctl[4] && !ctl[5] |-> cc_o[0] == (lvl[0] ~^ lns[0]))
        else $error("line one moved without option");
    a_line2_static: assert property (
        calm && ctl[9:8] != 2'h1 |-> cc_o[1] == (lvl[1] ~^ lns[1]))
        else $error("line two moved unselected");
    a_line4_static: assert property (
        calm && !ctl[11] && !ctl[7] |-> cc_o[3] == (lvl[3] ~^ lns[3]))
        else $error("line four moved unselected");
    a_idle_level: assert property (
        calm && !ctl[0] && (ctl[4] || ctl[5]) |-> cc_o[0] == (ctl[19] ~^ lns[0]))
        else $error("idle trigger level wrong");
    a_zero_period: assert property (
        zcfg && $rose(cc_o[0]) ##[1:25] $rose(cc_o[0]) |-> ##20 ($rose(cc_o[0]) || !zcfg))
        else $error("all-zero period not 20 clocks");
    a_power_off: assert property (
        calm && !sh_q[5][3] |-> !cable_power_o) else $error("cable power on while off");
    a_power_delay: assert property (
        $rose(cable_power_o) |-> pwr_q + 12'h2 >= pwr_exp && pwr_q <= pwr_exp + 12'h2)
        else $error("cable power delay wrong");
    a_index_single: assert property (
        index_pulse_o |=> !index_pulse_o) else $error("index pulse too long");

    c_trig: cover property ($rose(cc_o[0]));
    c_power: cover property ($rose(cable_power_o));
    c_index: cover property (index_pulse_o);
endmodule : trig_pulse_chk

bind camera_trigger_pulse_generator trig_pulse_chk #(.POWER_STEP(POWER_STEP)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
    .read_i(read_i), .rdata_o(rdata_o), .cc_o(cc_o), .index_pulse_o(index_pulse_o),
    .cable_power_o(cable_power_o));

// ==== test/trig_pin_model.sv ====
// model of the trigger, encoder and reference sources facing the generator
`timescale 1ns/1ps

module trig_pin_model
    import trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic ref_on_i,
    output pins_t pins_o
);
    // ==========================================================
    // pin levels
    logic [5:0] lvl_q = 6'h0;
    logic ref_q = 1'b0;

    // reference has its own period, unrelated to clk_i, and halts when off
    always begin
        #7.4;
        if (ref_on_i)
            ref_q = ~ref_q;
    end
    assign pins_o = {ref_q, lvl_q};

    // raise one source, hold it, drop it, hold again: slow holds mimic a lazy encoder
    task automatic edge_on(input int idx, input int hold);
        @(posedge clk_i);
        lvl_q[idx] <= 1'b1;
        repeat (hold) @(posedge clk_i);
        lvl_q[idx] <= 1'b0;
        repeat (hold) @(posedge clk_i);
    endtask : edge_on
endmodule : trig_pin_model

// ==== test/camera_trigger_pulse_generator_tb.sv ====
// self-checking bench for the camera trigger pulse generator
`timescale 1ns/1ps
`include "trig_cfg.svh"

module camera_trigger_pulse_generator_tb
    import trig_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic ref_on = 1'b0;
    logic [31:0] rdata_o;
    logic [3:0] cc_o;
    logic page_pulse_o, index_pulse_o, cable_power_o;
    pins_t pins;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    int cnt [0:5] = '{default: 0};
    int base [0:5];
    logic [5:0] prev_q = 6'h0;
    wire logic [5:0] outs = {index_pulse_o, page_pulse_o, cc_o};
    int src_tab [1:5] = '{1, 2, 3, 2, 2};
    logic [31:0] inv_base [0:5] = '{32'h201d, 32'h15, 32'h17, 32'h13, 32'h1d, 32'h1d};
    int inv_bit [0:5] = '{12, 14, 15, 17, 18, 16};
    int inv_cnt [0:5] = '{0, 0, 0, 0, 4, 5};

    camera_trigger_pulse_generator #(.POWER_STEP(10)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .ext_trig_i(pins.ext_trig),
        .line_trig_i(pins.line), .page_trig_i(pins.page), .enc_a_i(pins.enc_a),
        .enc_b_i(pins.enc_b), .enc_z_i(pins.enc_z), .ext_reference_input_i(pins.ext_ref),
        .cc_o(cc_o), .page_pulse_o(page_pulse_o), .index_pulse_o(index_pulse_o),
        .cable_power_o(cable_power_o));
    trig_pin_model src (.clk_i(clk_i), .ref_on_i(ref_on), .pins_o(pins));

    // ==========================================================
    // clock, rising-edge counters on the four lines and the page and index pulses, watchdog
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        prev_q <= outs;
        for (int k = 0; k < 6; k++)
            cnt[k] = cnt[k] + int'(outs[k] && !prev_q[k]);
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // bus tasks and compares; one idle cycle between strobes keeps drivers simple
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
        @(posedge clk_i);
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t value %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng

    // skip two rises so a partial first cycle is ignored, then time high and 4 periods
    task automatic meas(input int per, input int hl, input int hh, input int tol);
        realtime t0;
        realtime t1;
        repeat (2) @(posedge cc_o[0]);
        t0 = $realtime;
        @(negedge cc_o[0]);
        t1 = $realtime;
        chk_rng(int'(t1 - t0), hl, hh);
        repeat (4) @(posedge cc_o[0]);
        chk_rng(int'($realtime - t0), 4 * per - tol, 4 * per + tol);
        @(posedge clk_i);
    endtask : meas

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a <= 32; a += 4)
            rd(8'(a), 32'h0);
        wr(`OFS_DELAY, 32'hffff_ffff);
        wr(`OFS_WIDTH, 32'hffff_ffff);
        wr(`OFS_BLANK, 32'hffff_ffff);
        wr(`OFS_STATUS, 32'hffff_ffff);
        rd(`OFS_DELAY, 32'h0fff);
        rd(`OFS_WIDTH, 32'hffff);
        rd(`OFS_BLANK, 32'hffff);
        rd(`OFS_STATUS, 32'h0);
        // free run on line one through the second option
        wr(`OFS_DELAY, 32'h0);
        wr(`OFS_WIDTH, 32'h0);
        wr(`OFS_BLANK, 32'h0);
        wr(`OFS_LINES, 32'h01);
        wr(`OFS_CTRL, 32'h21);
        meas(100, 10, 20, 0);
        wr(`OFS_DELAY, 32'h1);
        wr(`OFS_WIDTH, 32'h2);
        wr(`OFS_BLANK, 32'h3);
        meas(220, 45, 60, 0);
        wr(`OFS_CTRL, 32'h8_0021);
        meas(220, 160, 175, 0);
        ref_on <= 1'b1;
        wr(`OFS_CTRL, 32'h421);
        meas(163, 25, 50, 10);
        // lines two, three and four with the external output option
        wr(`OFS_LINES, 32'h0f);
        base = cnt;
        wr(`OFS_CTRL, 32'h9d1);
        repeat (200) @(posedge clk_i);
        chk_rng(cnt[1] - base[1], 1, 100);
        chk_rng(cnt[2] - base[2], 0, 0);
        chk_rng(cnt[3] - base[3], 1, 100);
        ref_on <= 1'b0;
        // each start source gives one cycle per edge, index pin gives none
        wr(`OFS_DELAY, 32'h0);
        wr(`OFS_LINES, 32'h01);
        for (int m = 1; m <= 5; m++) begin
            wr(`OFS_CTRL, 32'h11 | 32'(m << 1));
            repeat (60) @(posedge clk_i);
            base = cnt;
            src.edge_on(src_tab[m], 60);
            src.edge_on(4, 20);
            chk_rng(cnt[0] - base[0], 1, 1);
            chk_rng(cnt[5] - base[5], 1, 1);
        end
        wr(`OFS_CTRL, 32'h1d);
        base = cnt;
        src.edge_on(0, 60);
        chk_rng(cnt[0] - base[0], 0, 0);
        // flipping an input invert on a low pin makes exactly one edge
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_CTRL, inv_base[i]);
            repeat (60) @(posedge clk_i);
            base = cnt;
            wr(`OFS_CTRL, inv_base[i] | (32'h1 << inv_bit[i]));
            repeat (60) @(posedge clk_i);
            chk_rng(cnt[inv_cnt[i]] - base[inv_cnt[i]], 1, 1);
        end
        // cable power delay at both ends of the selector
        for (int s = 0; s < 8; s += 7) begin
            wr(`OFS_POWER, 32'h8 | 32'(s));
            n = 0;
            while (cable_power_o !== 1'b1 && n < 200) begin
                @(posedge clk_i);
                n++;
            end
            chk_rng(n, (s + 1) * 10 - 3, (s + 1) * 10 + 3);
            wr(`OFS_POWER, 32'h0);
            repeat (3) @(posedge clk_i);
            chk({31'h0, cable_power_o}, 32'h0);
        end
        // stopped trigger with output invert, under two polarity masks
        wr(`OFS_CTRL, 32'h8_0020);
        wr(`OFS_LINES, 32'h0f);
        repeat (10) @(posedge clk_i);
        chk({28'h0, cc_o}, 32'h1);
        wr(`OFS_LINES, 32'h00);
        repeat (10) @(posedge clk_i);
        chk({28'h0, cc_o}, 32'he);
        report_and_stop();
    end
endmodule : camera_trigger_pulse_generator_tb
